//--- design/divide_select_sync_pkg.sv
// shared constants and types for the channel divider and phase-sync control
package divide_select_sync_pkg;
	// ----------------------------------------
	// field widths
	// ----------------------------------------
	localparam int unsigned DIV_SEL_W = 5;
	localparam int unsigned MUX_W = 2;
	localparam int unsigned PWR_W = 6;
	localparam int unsigned RATIO_W = 8;
	localparam int unsigned FB_W = 3;
	// ----------------------------------------
	// divide select codes
	// ----------------------------------------
	localparam logic [DIV_SEL_W-1:0] DIV_SEL_LAST = 5'h0C;
	localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 5'h00;
	// ----------------------------------------
	// output source select encodings
	// ----------------------------------------
	localparam logic [MUX_W-1:0] SRC_DIVIDE_SELECT = 2'h0;
	localparam logic [MUX_W-1:0] SRC_VCO = 2'h1;
	localparam logic [MUX_W-1:0] SRC_SYSREF = 2'h2;
	localparam logic [MUX_W-1:0] SRC_RESET = 2'h1;
	// ----------------------------------------
	// included feedback divide values and special ratios
	// ----------------------------------------
	localparam logic [FB_W-1:0] FB_ONE = 3'h1;
	localparam logic [FB_W-1:0] FB_FOUR = 3'h4;
	localparam logic [FB_W-1:0] FB_SIX = 3'h6;
	localparam logic [RATIO_W-1:0] RATIO_24 = 8'h18;
	localparam logic [RATIO_W-1:0] RATIO_192 = 8'hC0;
	// ----------------------------------------
	// host-side limits and timing
	// ----------------------------------------
	localparam logic [PWR_W-1:0] PWR_MAX_MID = 6'h1F;
	localparam logic [PWR_W-1:0] PWR_MAX_HIGH = 6'h14;
	localparam logic [PWR_W-1:0] PWR_RESET = 6'h0F;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SYNC_PULSE_NS = 100;
	localparam int unsigned SYNC_PULSE_CYC =
		(SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// per-stage factors of one divide select code
	typedef struct packed
	{
		logic [1:0] f1;
		logic [1:0] f2;
		logic [3:0] f3;
		logic [2:0] f4;
	} stage_factors_s;
endpackage : divide_select_sync_pkg

//--- design/divide_select_sync_if.sv
// link between host controller and divider/phase-sync control
interface divide_select_sync_if;
	logic [4:0] divide_select; // channel divide code
	logic [1:0] output_a_source_select; // output a source
	logic [1:0] output_b_source_select; // output b source
	logic [5:0] output_a_power_level; // output a power
	logic [5:0] output_b_power_level; // output b power
	logic output_a_disable; // output a off
	logic output_b_disable; // output b off
	logic chip_enable; // chip enable pin, high = run
	logic power_off; // software power-down bit
	logic freq_calibration_trigger; // pulse: one cycle, set after power-down exit
	logic phase_align_mode; // phase-align enable bit
	logic align_pin_disregard; // ignore the align pin
	logic align_pin; // align request pin
	logic powered_down; // device in power-down
	logic calibrating; // calibration in progress
	logic phase_aligned; // deterministic phase reached
	modport device (
		input divide_select, output_a_source_select, output_b_source_select,
		input output_a_power_level, output_b_power_level, output_a_disable,
		input output_b_disable, chip_enable, power_off, freq_calibration_trigger,
		input phase_align_mode, align_pin_disregard, align_pin,
		output powered_down, calibrating, phase_aligned
	);
	modport host (
		output divide_select, output_a_source_select, output_b_source_select,
		output output_a_power_level, output_b_power_level, output_a_disable,
		output output_b_disable, chip_enable, power_off, freq_calibration_trigger,
		output phase_align_mode, align_pin_disregard, align_pin,
		input powered_down, calibrating, phase_aligned
	);
endinterface : divide_select_sync_if

//--- design/divide_select_sync_device.sv
// device end: channel divider decode, power gating and phase-sync control
module divide_select_sync_device (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reference_input,
	input wire logic cal_done,
	input wire logic settle_done,
	input wire logic fractional_mode,
	input wire logic modulator_wait_done,
	divide_select_sync_if.device link,
	output logic [1:0] stage_one_factor,
	output logic [1:0] stage_two_factor,
	output logic [3:0] stage_three_factor,
	output logic [2:0] stage_four_factor,
	output logic [7:0] divide_ratio,
	output logic divider_powered,
	output logic [2:0] feedback_extra_factor,
	output logic [5:0] output_a_level,
	output logic [5:0] output_b_level,
	output logic divide_select_out,
	output logic sync_reclocked
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// code to stage factors
	function automatic divide_select_sync_pkg::stage_factors_s decode_sel(input logic [4:0] sel);
		divide_select_sync_pkg::stage_factors_s s;
		s.f1 = 2'h2; // first stage always 2
		s.f2 = sel[0] ? 2'h2 : 2'h3;
		if (sel == 5'h00)
		begin
			s.f2 = 2'h1;
		end
		s.f3 = 4'h1;
		s.f4 = 3'h1;
		if (sel >= 5'h03 && sel <= 5'h04)
			s.f3 = 4'h2;
		else if (sel >= 5'h05 && sel <= 5'h06)
			s.f3 = 4'h4;
		else if (sel >= 5'h07)
			s.f3 = 4'h8;
		if (sel >= 5'h09 && sel <= 5'h0A)
			s.f4 = 3'h2;
		else if (sel >= 5'h0B)
			s.f4 = 3'h4;
		if (sel == 5'h01)
			s.f2 = 2'h2;
		if (sel == 5'h02)
			s.f2 = 2'h3;
		if (sel >= 5'h03)
			s.f2 = sel[0] ? 2'h2 : 2'h3;
		return s;
	endfunction
	// product of factors
	function automatic logic [7:0] ratio_of(input divide_select_sync_pkg::stage_factors_s s);
		logic [9:0] p;
		p = 10'(s.f1) * 10'(s.f2) * 10'(s.f3) * 10'(s.f4); // ratio is product
		return p[7:0];
	endfunction
	// true when a source select uses the divider
	function automatic logic uses_div(input logic [1:0] src, input logic allow_sysref);
		return (src == divide_select_sync_pkg::SRC_DIVIDE_SELECT) ||
			(allow_sysref && src == divide_select_sync_pkg::SRC_SYSREF);
	endfunction

	divide_select_sync_pkg::stage_factors_s fac; // decoded factors
	logic [7:0] ratio; // decoded ratio
	logic pwr_d; // next divider power
	logic pd_d; // next power-down
	logic [7:0] cnt_q; // divider counter
	logic ref_q; // previous reference level
	logic ref_rise; // reference rising edge
	logic pin_q; // previous align pin
	logic mode_q; // previous mode bit
	logic req_q; // pending align request
	logic waiting_q; // waiting for settle

	always_comb
	begin
		fac = decode_sel(link.divide_select);
		ratio = ratio_of(fac);
		// divider power from sources only, not output disables
		pwr_d = uses_div(link.output_a_source_select, 1'b0) ||
			uses_div(link.output_b_source_select, 1'b1);
		pd_d = !link.chip_enable || link.power_off;
		ref_rise = reference_input && !ref_q;
	end

	// ----------------------------------------
	// registered decode outputs
	// ----------------------------------------
	// factors, ratio and divider power
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			stage_one_factor <= 2'h2;
			stage_two_factor <= 2'h1;
			stage_three_factor <= 4'h1;
			stage_four_factor <= 3'h1;
			divide_ratio <= 8'h02;
			divider_powered <= 1'b0;
		end
		else
		begin
			stage_one_factor <= fac.f1; // four segments
			stage_two_factor <= fac.f2;
			stage_three_factor <= fac.f3;
			stage_four_factor <= fac.f4;
			divide_ratio <= ratio;
			divider_powered <= pwr_d && !pd_d;
		end
	end

	// feedback extra factor in phase-align mode
	always_ff @(posedge mclk)
	begin
		if (rst)
			feedback_extra_factor <= divide_select_sync_pkg::FB_ONE;
		else if (!link.phase_align_mode)
			feedback_extra_factor <= divide_select_sync_pkg::FB_ONE;
		else if (link.output_a_source_select == divide_select_sync_pkg::SRC_VCO &&
			link.output_b_source_select == divide_select_sync_pkg::SRC_VCO)
			feedback_extra_factor <= divide_select_sync_pkg::FB_ONE;
		else if ((ratio % 8'h03) == 8'h00 && ratio != divide_select_sync_pkg::RATIO_24 &&
			ratio != divide_select_sync_pkg::RATIO_192)
			feedback_extra_factor <= divide_select_sync_pkg::FB_SIX;
		else
			feedback_extra_factor <= divide_select_sync_pkg::FB_FOUR;
	end

	// output levels follow immediately, no lock impact
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			output_a_level <= 6'h00;
			output_b_level <= 6'h00;
		end
		else
		begin
			output_a_level <= link.output_a_disable ? 6'h00 : link.output_a_power_level;
			output_b_level <= link.output_b_disable ? 6'h00 : link.output_b_power_level;
		end
	end

	// ----------------------------------------
	// divider counter
	// ----------------------------------------
	// held in reset while unpowered
	always_ff @(posedge mclk)
	begin
		if (rst || !divider_powered)
		begin
			cnt_q <= 8'h00;
			divide_select_out <= 1'b0;
		end
		else if (cnt_q >= (divide_ratio >> 1) - 8'h01)
		begin
			cnt_q <= 8'h00;
			divide_select_out <= !divide_select_out;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end

	// ----------------------------------------
	// power-down and calibration
	// ----------------------------------------
	// power-down state and calibration flag
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			link.powered_down <= 1'b0;
			link.calibrating <= 1'b0;
		end
		else
		begin
			link.powered_down <= pd_d;
			if (pd_d)
				link.calibrating <= 1'b0;
			else if (link.freq_calibration_trigger)
				link.calibrating <= 1'b1;
			else if (cal_done)
				link.calibrating <= 1'b0;
		end
	end

	// ----------------------------------------
	// phase synchronisation
	// ----------------------------------------
	// edge history
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ref_q <= 1'b0;
			pin_q <= 1'b0;
			mode_q <= 1'b0;
		end
		else
		begin
			ref_q <= reference_input;
			pin_q <= link.align_pin;
			mode_q <= link.phase_align_mode;
		end
	end

	// request capture and reclock to reference edge
	always_ff @(posedge mclk)
	begin
		if (rst || link.powered_down)
		begin
			req_q <= 1'b0;
			sync_reclocked <= 1'b0;
		end
		else
		begin
			sync_reclocked <= 1'b0;
			if (req_q && ref_rise)
			begin
				req_q <= 1'b0;
				sync_reclocked <= 1'b1;
			end
			// pin edge, one request each mode bit rising edge
			if ((link.align_pin && !pin_q && !link.align_pin_disregard &&
				link.phase_align_mode) || (link.phase_align_mode && !mode_q))
				req_q <= 1'b1;
		end
	end

	// phase aligned after calibration, settle and modulator wait
	always_ff @(posedge mclk)
	begin
		if (rst || link.powered_down || !link.phase_align_mode)
		begin
			waiting_q <= 1'b0;
			link.phase_aligned <= 1'b0;
		end
		else if (sync_reclocked)
		begin
			waiting_q <= 1'b1;
			link.phase_aligned <= 1'b0;
		end
		else if (waiting_q && !link.calibrating && cal_done && settle_done &&
			(!fractional_mode || modulator_wait_done))
		begin
			waiting_q <= 1'b0;
			link.phase_aligned <= 1'b1;
		end
	end
endmodule : divide_select_sync_device

//--- design/divide_select_sync_host.sv
// host end: drives configuration onto the link
module divide_select_sync_host (
	input wire logic mclk,
	input wire logic rst,
	divide_select_sync_if.host link,
	input wire logic cfg_write,
	input wire logic [4:0] cfg_divide_select,
	input wire logic [1:0] cfg_source_a,
	input wire logic [1:0] cfg_source_b,
	input wire logic [5:0] cfg_power_a,
	input wire logic [5:0] cfg_power_b,
	input wire logic cfg_high_band,
	input wire logic cfg_mid_band,
	input wire logic cfg_use_a,
	input wire logic cfg_use_b,
	input wire logic cfg_power_off,
	input wire logic cfg_chip_enable,
	input wire logic cfg_phase_align,
	input wire logic cfg_use_pin,
	input wire logic sync_pulse_req,
	output logic cfg_rejected
);
	logic pd_q; // last seen power-down
	logic [1:0] pulse_q; // align pin pulse count
	logic [5:0] lim_a; // clamped power a
	logic [5:0] lim_b; // clamped power b

	// power clamp by band
	function automatic logic [5:0] clamp(input logic [5:0] p, input logic hi, input logic mid);
		if (hi && p > divide_select_sync_pkg::PWR_MAX_HIGH)
			return divide_select_sync_pkg::PWR_MAX_HIGH;
		if (mid && p > divide_select_sync_pkg::PWR_MAX_MID)
			return divide_select_sync_pkg::PWR_MAX_MID;
		return p;
	endfunction

	always_comb
	begin
		lim_a = clamp(cfg_power_a, cfg_high_band, cfg_mid_band);
		lim_b = clamp(cfg_power_b, cfg_high_band, cfg_mid_band);
	end

	// ----------------------------------------
	// configuration writes
	// ----------------------------------------
	// registered link fields
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			link.divide_select <= divide_select_sync_pkg::DIV_SEL_RESET;
			link.output_a_source_select <= divide_select_sync_pkg::SRC_RESET;
			link.output_b_source_select <= divide_select_sync_pkg::SRC_RESET;
			link.output_a_power_level <= divide_select_sync_pkg::PWR_RESET;
			link.output_b_power_level <= divide_select_sync_pkg::PWR_RESET;
			link.output_a_disable <= 1'b0;
			link.output_b_disable <= 1'b0;
			link.chip_enable <= 1'b1;
			link.power_off <= 1'b0;
			link.phase_align_mode <= 1'b0;
			link.align_pin_disregard <= 1'b1;
			cfg_rejected <= 1'b0;
		end
		else if (cfg_write)
		begin
			cfg_rejected <= cfg_divide_select > divide_select_sync_pkg::DIV_SEL_LAST;
			if (cfg_divide_select <= divide_select_sync_pkg::DIV_SEL_LAST)
				link.divide_select <= cfg_divide_select;
			// unused outputs routed to vco
			link.output_a_source_select <= cfg_use_a ? cfg_source_a : divide_select_sync_pkg::SRC_VCO;
			link.output_b_source_select <= cfg_use_b ? cfg_source_b : divide_select_sync_pkg::SRC_VCO;
			link.output_a_power_level <= lim_a;
			link.output_b_power_level <= lim_b;
			link.output_a_disable <= !cfg_use_a;
			link.output_b_disable <= !cfg_use_b;
			link.chip_enable <= cfg_chip_enable;
			link.power_off <= cfg_power_off;
			link.phase_align_mode <= cfg_phase_align; // software align edge
			link.align_pin_disregard <= !(cfg_phase_align && cfg_use_pin);
		end
		else
			cfg_rejected <= 1'b0;
	end

	// recalibrate after power-down exit
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pd_q <= 1'b0;
			link.freq_calibration_trigger <= 1'b0;
		end
		else
		begin
			pd_q <= link.powered_down;
			link.freq_calibration_trigger <= pd_q && !link.powered_down;
		end
	end

	// align pin pulse for timing-critical requests
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pulse_q <= 2'h0;
			link.align_pin <= 1'b0;
		end
		else if (sync_pulse_req && pulse_q == 2'h0)
		begin
			pulse_q <= 2'(divide_select_sync_pkg::SYNC_PULSE_CYC);
			link.align_pin <= 1'b1;
		end
		else if (pulse_q != 2'h0)
		begin
			pulse_q <= pulse_q - 2'h1;
			link.align_pin <= pulse_q != 2'h1;
		end
	end
endmodule : divide_select_sync_host

//--- testbench/divide_select_sync_props.sv
// concurrent checks on the host and device link signals
module divide_select_sync_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] divide_select,
	input wire logic chip_enable,
	input wire logic power_off,
	input wire logic freq_calibration_trigger,
	input wire logic phase_align_mode,
	input wire logic align_pin_disregard,
	input wire logic align_pin,
	input wire logic powered_down,
	input wire logic calibrating,
	input wire logic phase_aligned
);
	// ----------------------------------------
	// clocking and assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	pd_entry_a: assert property ((!chip_enable || power_off) |=> powered_down)
		else $error("power-down not entered");
	pd_exit_a: assert property ((chip_enable && !power_off) |=> !powered_down)
		else $error("power-down not left");
	recal_exit_a: assert property
		($fell(powered_down) && !$past(rst) |-> ##[1:3] freq_calibration_trigger)
		else $error("no recalibration after power-down exit");
	cal_pulse_a: assert property (freq_calibration_trigger |=> !freq_calibration_trigger)
		else $error("calibration trigger longer than one cycle");
	code_range_a: assert property (divide_select <= 5'h0C)
		else $error("invalid divide code on link");
	disregard_off_a: assert property (!phase_align_mode |-> align_pin_disregard)
		else $error("pin not disregarded with align mode off");
	pin_pulse_a: assert property ($rose(align_pin) |-> ##1 align_pin ##1 !align_pin)
		else $error("align pin pulse not two cycles");
	pd_no_cal_a: assert property (powered_down [*2] |-> !calibrating)
		else $error("calibrating while powered down");
	pd_no_align_a: assert property (powered_down [*2] |-> !phase_aligned)
		else $error("aligned while powered down");
	// main scenarios reached
	cover property ($rose(phase_aligned));
	cover property ($rose(powered_down));
	cover property ($rose(align_pin));
endmodule // divide_select_sync_props

//--- testbench/tb_channel_divider_phase_sync_ctrl.sv
// self-checking bench joining host and device ends over the link
module tb_channel_divider_phase_sync_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic mclk = 0, rst = 1, ref_in = 0, cal_done = 1, frac = 0, mwd = 1;
	logic cfg_write = 0, poff = 0, ce = 1, pam = 0, pin = 0, req = 0;
	logic hb = 0, mb = 0, ua = 1, ub = 1, sd = 1; // band, output use and settle stimulus
	int t0; // cycle stamp for divider half period
	logic [4:0] cd = 5'h00;
	logic [1:0] sa = 2'h1, sb = 2'h1, f1, f2;
	logic [5:0] pa = 6'h0F, pb = 6'h0F, la, lb;
	logic [3:0] f3;
	logic [2:0] f4, fb;
	logic [2:0] rc = 3'h0; // reference divider
	logic [7:0] ratio;
	logic dpow, cout, srk, rej;
	int failures = 0, n_checks = 0, cyc = 0, n_sync = 0, n_rej = 0;
	int r, s2, m, s4, base;
	int rt[13] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192}; // ratio per code
	always #25 mclk = ~mclk;
	divide_select_sync_if link ();
	divide_select_sync_host i_divide_select_sync_host (.mclk(mclk), .rst(rst), .link(link),
		.cfg_write(cfg_write), .cfg_divide_select(cd), .cfg_source_a(sa), .cfg_source_b(sb),
		.cfg_power_a(pa), .cfg_power_b(pb), .cfg_high_band(hb), .cfg_mid_band(mb),
		.cfg_use_a(ua), .cfg_use_b(ub), .cfg_power_off(poff), .cfg_chip_enable(ce),
		.cfg_phase_align(pam), .cfg_use_pin(pin), .sync_pulse_req(req), .cfg_rejected(rej));
	divide_select_sync_device i_divide_select_sync_device (.mclk(mclk), .rst(rst), .reference_input(ref_in),
		.cal_done(cal_done), .settle_done(sd), .fractional_mode(frac),
		.modulator_wait_done(mwd), .link(link), .stage_one_factor(f1), .stage_two_factor(f2),
		.stage_three_factor(f3), .stage_four_factor(f4), .divide_ratio(ratio),
		.divider_powered(dpow), .feedback_extra_factor(fb), .output_a_level(la),
		.output_b_level(lb), .divide_select_out(cout), .sync_reclocked(srk));
	divide_select_sync_props i_divide_select_sync_props (.mclk(mclk), .rst(rst),
		.divide_select(link.divide_select), .chip_enable(link.chip_enable),
		.power_off(link.power_off), .freq_calibration_trigger(link.freq_calibration_trigger),
		.phase_align_mode(link.phase_align_mode), .align_pin_disregard(link.align_pin_disregard),
		.align_pin(link.align_pin), .powered_down(link.powered_down),
		.calibrating(link.calibrating), .phase_aligned(link.phase_aligned));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wt(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// one configuration write, then let link and decode settle
	task wr;
		@(posedge mclk) cfg_write <= 1'b1;
		@(posedge mclk) cfg_write <= 1'b0;
		wt(4);
	endtask
	// reference clock, pulse counters and cycle ceiling
	always @(posedge mclk)
	begin
		rc <= rc + 3'h1;
		ref_in <= rc[2];
		n_sync += (srk === 1'b1);
		// reclocked pulse only while reference stands high after its rise
		if (srk === 1'b1)
			check("sync on ref", ref_in, 1'b1);
		n_rej += (rej === 1'b1);
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		wt(2);
		rst <= 1'b0;
		wt(1);
		check("ratio rst", ratio, 8'h02);
		check("fb rst", fb, 3'h1);
		$display("test reset done");
		pam <= 1'b1;
		sa <= 2'h0;
		for (int i = 0; i < 13; i++)
		begin
			cd <= 5'(i);
			wr();
			r = rt[i];
			s2 = (r == 2) ? 1 : ((r % 3 == 0) ? 3 : 2);
			m = r / (2 * s2);
			s4 = (m > 8) ? m / 8 : 1;
			check("stage1", f1, 2);
			check("stage2", f2, s2);
			check("stage3", f3, m / s4);
			check("stage4", f4, s4);
			check("product", 32'(f1) * 32'(f2) * 32'(f3) * 32'(f4), r);
			check("ratio", ratio, r);
			check("fb", fb, (r % 3 == 0 && r != 24 && r != 192) ? 6 : 4);
		end
		for (int i = 13; i < 32; i += 18)
		begin
			cd <= 5'(i);
			base = n_rej;
			wr();
			check("ratio kept", ratio, 8'hC0);
			check("rejected", n_rej - base, 1);
		end
		$display("test decode done");
		cd <= 5'h0B;
		for (int a = 0; a < 3; a++)
			for (int b = 0; b < 3; b++)
			begin
				sa <= 2'(a);
				sb <= 2'(b);
				wr();
				check("div power", dpow, a == 0 || b == 0 || b == 2);
				check("fb src", fb, (a == 1 && b == 1) ? 1 : 4);
			end
		$display("test gating done");
		sa <= 2'h0;
		for (int k = 0; k < 2; k++)
		begin
			if (k == 0)
				poff <= 1'b1;
			else
				ce <= 1'b0;
			wr();
			check("pd on", link.powered_down, 1'b1);
			check("div off", dpow, 1'b0);
			check("div held", cout, 1'b0);
			poff <= 1'b0;
			ce <= 1'b1;
			wr();
			check("pd off", link.powered_down, 1'b0);
			check("div on", dpow, 1'b1);
			// divider restarts cleanly: half period of ratio 128
			@(posedge cout);
			t0 = cyc;
			@(negedge cout);
			check("div half", cyc - t0, rt[11] / 2);
			wt(1);
		end
		$display("test power-down done");
		pam <= 1'b0;
		wr();
		cal_done <= 1'b0;
		sd <= 1'b0;
		frac <= 1'b1;
		mwd <= 1'b0;
		base = n_sync;
		pam <= 1'b1;
		wr();
		wt(20);
		check("sw sync", n_sync - base, 1);
		check("wait cal", link.phase_aligned, 1'b0);
		cal_done <= 1'b1;
		wt(20);
		check("wait mod", link.phase_aligned, 1'b0);
		mwd <= 1'b1;
		wt(20);
		check("wait settle", link.phase_aligned, 1'b0);
		sd <= 1'b1;
		for (int t = 0; t < 50 && link.phase_aligned !== 1'b1; t++)
			wt(1);
		check("aligned", link.phase_aligned, 1'b1);
		pa <= 6'h05;
		wr();
		check("level a", la, 6'h05);
		check("level b", lb, 6'h0F);
		check("lock kept", link.phase_aligned, 1'b1);
		$display("test software sync done");
		pin <= 1'b1;
		wr();
		base = n_sync;
		req <= 1'b1;
		wt(1);
		req <= 1'b0;
		wt(40);
		check("pin sync", n_sync - base, 1);
		pin <= 1'b0;
		wr();
		base = n_sync;
		req <= 1'b1;
		wt(1);
		req <= 1'b0;
		wt(20);
		check("pin ignored", n_sync - base, 0);
		$display("test pin sync done");
		// power clamp per band, unused outputs routed to vco
		hb <= 1'b1;
		pa <= 6'h30;
		wr();
		check("clamp high", la, 6'h14);
		hb <= 1'b0;
		mb <= 1'b1;
		pa <= 6'h3F;
		wr();
		check("clamp mid", la, 6'h1F);
		ua <= 1'b0;
		ub <= 1'b0;
		wr();
		check("unused a vco", link.output_a_source_select, 2'h1);
		check("unused b vco", link.output_b_source_select, 2'h1);
		check("a disabled", la, 6'h00);
		check("b disabled", lb, 6'h00);
		check("div idle", dpow, 1'b0);
		check("fb both vco", fb, 3'h1);
		check("lock kept off", link.phase_aligned, 1'b1);
		$display("test output limits done");
		end_of_test();
	end
endmodule // tb_channel_divider_phase_sync_ctrl
